// ===== src/fpm_monitor.sv
// fault protection monitor of a step-down point-of-load converter
//
// Functional notes
// - protections latch or retry every 130 ms
// - overcurrent 60..180 percent, 11 steps, default 180
// - overvoltage 110..130 percent, default 130
// - overvoltage threshold never below 1.0 V
// - undervoltage 75..85 percent, default 75
// - turn-off 6 us after threshold crossing (overcurrent turns off at once, without the 6 us filter)
// - overtemperature off at 130, resume at 120
// - tracking off by default, ramp only, 250 mV
// - warning at 120 C, 3 C hysteresis, status
// - warning asserts no sooner than 6 us
// - power good inside 90/95..110 percent window
// - power good changes no sooner than 6 us
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_cfg.svh"
module fpm_monitor #(
  parameter int RETRY_CYCLES = `FPM_RETRY_CYCLES,
  parameter int QUAL_CYCLES = `FPM_QUAL_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [`FPM_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // measurements (mV, mA, degC)
  input wire logic [15:0] voutMv,
  input wire logic [15:0] vsetMv,
  input wire logic [15:0] trackRefMv,
  input wire logic [15:0] ioutMa,
  input wire logic [15:0] iratedMa,
  input wire logic signed [9:0] tempC,
  input wire logic rampActive,
  // outputs
  output logic turnOff,
  output logic power_good_out,
  output logic otWarning,
  output logic irq
);
  import fpm_pkg::*;

  // ----------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------
  if (RETRY_CYCLES < 1) begin : g_bad
    $error("RETRY_CYCLES must be at least 1");
  end

  localparam logic [31:0] RETRY_LAST = 32'(RETRY_CYCLES - 1);

  fpm_mon_t r;
  fpm_mon_t next_r;
  fpm_qual_if #(.N(`FPM_CHANNELS)) qi ();

  fpm_filter #(.QUAL_CYCLES(QUAL_CYCLES)) u_filt (
    .clk(clk),
    .rst(rst),
    .q(qi.flt)
  );

  // ----------------------------------------------------------------------
  // config decode
  // ----------------------------------------------------------------------
  logic [3:0] ocSel;
  logic [1:0] ovSel;
  logic [1:0] uvSel;
  logic pgSel;
  logic trkEn;
  logic [4:0] latchSel;
  logic [7:0] ocPct;
  logic [7:0] ovPct;
  logic [7:0] uvPct;
  logic [7:0] pgLoPct;

  assign ocSel = r.cfg[`FPM_CFG_OC_LSB +: 4];
  assign ovSel = r.cfg[`FPM_CFG_OV_LSB +: 2];
  assign uvSel = r.cfg[`FPM_CFG_UV_LSB +: 2];
  assign pgSel = r.cfg[`FPM_CFG_PG_BIT];
  assign trkEn = r.cfg[`FPM_CFG_TRK_BIT];
  assign latchSel = r.cfg[`FPM_CFG_LATCH_LSB +: 5];

  // percent per setting, out-of-range codes clamp to the top step
  always_comb begin
    ocPct = 8'(`FPM_OC_BASE + `FPM_OC_STEP * ((ocSel > 4'(`FPM_OC_MAXSEL)) ? `FPM_OC_MAXSEL : ocSel));
    ovPct = 8'(`FPM_OV_BASE + `FPM_OV_STEP * ((ovSel > 2'(`FPM_OV_MAXSEL)) ? `FPM_OV_MAXSEL : ovSel));
    uvPct = 8'(`FPM_UV_BASE + `FPM_UV_STEP * ((uvSel > 2'(`FPM_UV_MAXSEL)) ? `FPM_UV_MAXSEL : uvSel));
    pgLoPct = 8'(`FPM_PG_LO_BASE + `FPM_PG_LO_STEP * pgSel);
  end

  // ----------------------------------------------------------------------
  // comparators, scaled by 100 to avoid division
  // ----------------------------------------------------------------------
  logic [31:0] vout100;
  logic [31:0] iout100;
  logic [31:0] ovLim;
  logic [31:0] trkErr;
  logic ocRaw;
  logic ovRaw;
  logic uvRaw;
  logic otRaw;
  logic trkRaw;
  logic pgRaw;
  logic runNow;

  assign runNow = (r.st == FPM_RUN);
  assign vout100 = 32'(voutMv) * 32'd100;
  assign iout100 = 32'(ioutMa) * 32'd100;
  // threshold floor of 1.0 V whatever the percent
  assign ovLim = (32'(vsetMv) * 32'(ovPct) < 32'(`FPM_OV_FLOOR_MV) * 32'd100) ?
                 32'(`FPM_OV_FLOOR_MV) * 32'd100 : 32'(vsetMv) * 32'(ovPct);
  assign trkErr = (voutMv >= trackRefMv) ? 32'(voutMv - trackRefMv) : 32'(trackRefMv - voutMv);

  always_comb begin
    ocRaw = iout100 > 32'(iratedMa) * 32'(ocPct);
    ovRaw = vout100 > ovLim;
    uvRaw = runNow && !rampActive && (vout100 < 32'(vsetMv) * 32'(uvPct));
    otRaw = tempC >= $signed(10'(`FPM_OT_TRIP_C));
    trkRaw = trkEn && rampActive && runNow && (trkErr > 32'(`FPM_TRK_MV));
    pgRaw = (vout100 >= 32'(vsetMv) * 32'(pgLoPct)) &&
            (vout100 <= 32'(vsetMv) * 32'(`FPM_PG_HI));
  end

  assign qi.raw = {pgRaw, r.warnRaw, trkRaw, otRaw, uvRaw, ovRaw};

  // ----------------------------------------------------------------------
  // fault vector (overcurrent acts at once, others after the filter)
  // ----------------------------------------------------------------------
  logic [4:0] faultVec;
  logic faultAny;
  logic latchHit;
  logic cfgWrite;

  assign faultVec = {qi.qual[`FPM_CH_TRK], qi.qual[`FPM_CH_OT], qi.qual[`FPM_CH_UV],
                     qi.qual[`FPM_CH_OV], ocRaw};
  assign faultAny = runNow && |faultVec;
  assign latchHit = |(faultVec & latchSel);
  assign cfgWrite = regWr && (regAddr == `FPM_OFS_CFG);

  // ----------------------------------------------------------------------
  // next state: registers, fault sequencer, hysteresis
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    // read data, valid in the cycle after the strobe
    next_r.rdata = 32'h0000_0000;
    if (regRd) begin
      unique case (regAddr)
        `FPM_OFS_CFG: next_r.rdata = r.cfg;
        `FPM_OFS_STATUS: next_r.rdata = 32'(r.status);
        `FPM_OFS_MASK: next_r.rdata = 32'(r.mask);
        `FPM_OFS_LIVE: next_r.rdata = 32'({r.warnRaw, r.otHot, qi.qual, r.st});
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end
    // writes
    if (cfgWrite) begin
      next_r.cfg = 32'(regWdata[14:0]);
    end
    if (regWr && regAddr == `FPM_OFS_MASK) begin
      next_r.mask = regWdata[5:0];
    end
    if (regWr && regAddr == `FPM_OFS_STATUS) begin
      next_r.status = r.status & ~regWdata[5:0];
    end
    // sticky events, set wins over the clear
    if (faultAny) begin
      next_r.status[4:0] = next_r.status[4:0] | faultVec;
    end
    if (qi.qual[`FPM_CH_WARN]) begin
      next_r.status[`FPM_EV_WARN] = 1'b1;
    end
    // warning level with hysteresis
    // signed limits keep sub-zero readings from looking hot
    if (tempC >= $signed(10'(`FPM_WARN_SET_C))) begin
      next_r.warnRaw = 1'b1;
    end else if (tempC <= $signed(10'(`FPM_WARN_SET_C - `FPM_WARN_HYST_C))) begin
      next_r.warnRaw = 1'b0;
    end
    // overtemperature hold until cooled to the resume level
    if (qi.qual[`FPM_CH_OT]) begin
      next_r.otHot = 1'b1;
    end else if (tempC <= $signed(10'(`FPM_OT_RESUME_C))) begin
      next_r.otHot = 1'b0;
    end
    // fault sequencer
    unique case (r.st)
      FPM_RUN: begin
        next_r.cnt = 32'h0000_0000;
        if (faultAny) begin
          next_r.st = latchHit ? FPM_LATCHED : FPM_RETRY;
        end
        if (qi.qual[`FPM_CH_OT]) begin
          next_r.otHot = 1'b1;
        end
      end
      FPM_RETRY: begin
        if (r.cnt != RETRY_LAST) begin
          next_r.cnt = r.cnt + 32'h0000_0001;
        end else if (!r.otHot) begin
          next_r.st = FPM_RUN;
        end
      end
      FPM_LATCHED: begin
        if (cfgWrite) begin
          next_r.st = FPM_RUN;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r.cfg <= `FPM_CFG_RESET;
      r.status <= 6'h00;
      r.mask <= 6'h00;
      r.st <= FPM_RUN;
      r.cnt <= 32'h0000_0000;
      r.rdata <= 32'h0000_0000;
      r.otHot <= 1'b0;
      r.warnRaw <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign regRdata = r.rdata;
  assign turnOff = !runNow;
  assign power_good_out = qi.qual[`FPM_CH_PG];
  assign otWarning = qi.qual[`FPM_CH_WARN];
  assign irq = |(r.status & r.mask);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  retry_entry_a: assert property (faultAny && !latchHit |=> r.st == FPM_RETRY && turnOff)
    else $error("non-latching fault did not enter retry");
  retry_hold_a: assert property (r.st == FPM_RETRY && r.cnt < RETRY_LAST |=> r.st == FPM_RETRY)
    else $error("retry left before its period");
  oc_default_a: assert property ($rose(ocRaw) && r.cfg[3:0] == 4'hA |->
      32'(ioutMa) * 32'd100 > 32'(iratedMa) * 32'd180)
    else $error("overcurrent default level wrong");
  ov_range_a: assert property (ovRaw |-> vout100 > 32'(vsetMv) * 32'd110 || voutMv > 16'd1000)
    else $error("overvoltage tripped below its lowest level");
  ov_floor_a: assert property (ovRaw |-> voutMv > 16'(`FPM_OV_FLOOR_MV))
    else $error("overvoltage tripped below the floor");
  uv_range_a: assert property (uvRaw |-> vout100 < 32'(vsetMv) * 32'd85)
    else $error("undervoltage tripped above its top level");
  ov_off_a: assert property (runNow && qi.qual[`FPM_CH_OV] |=> turnOff)
    else $error("overvoltage did not turn off");
  ot_resume_a: assert property (r.st == FPM_RETRY && r.otHot |=> !runNow)
    else $error("resumed while still hot");
  trk_gate_a: assert property (trkRaw |-> trkEn && rampActive)
    else $error("tracking fault outside ramp or disabled");
  warn_hyst_a: assert property ($fell(r.warnRaw) |-> $past(tempC) <= 10'sd117)
    else $error("warning cleared inside hysteresis");
  warn_late_a: assert property ($rose(otWarning) |-> $past(r.warnRaw, 2))
    else $error("warning asserted without a held cause");
  pg_window_a: assert property ($rose(power_good_out) |-> $past(pgRaw))
    else $error("power good rose outside the window");
  pg_delay_a: assert property ($changed(power_good_out) |-> $past(pgRaw, 2) == power_good_out)
    else $error("power good changed too early");
  latch_hold_a: assert property (r.st == FPM_LATCHED && !cfgWrite |=> r.st == FPM_LATCHED)
    else $error("latched fault released without config write");

endmodule
`default_nettype wire

// ===== src/fpm_cfg.svh
// offsets, field positions, reset values and timing counts of the fault monitor
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define FPM_ADDR_W 8
`define FPM_OFS_CFG 8'h00
`define FPM_OFS_STATUS 8'h04
`define FPM_OFS_MASK 8'h08
`define FPM_OFS_LIVE 8'h0C

// ----------------------------------------------------------------------
// config fields and reset value
// ----------------------------------------------------------------------
`define FPM_CFG_OC_LSB 0
`define FPM_CFG_OV_LSB 4
`define FPM_CFG_UV_LSB 6
`define FPM_CFG_PG_BIT 8
`define FPM_CFG_TRK_BIT 9
`define FPM_CFG_LATCH_LSB 10
`define FPM_CFG_RESET 32'h0000_002A

// ----------------------------------------------------------------------
// status / mask bit positions
// ----------------------------------------------------------------------
`define FPM_EV_OC 0
`define FPM_EV_OV 1
`define FPM_EV_UV 2
`define FPM_EV_OT 3
`define FPM_EV_TRK 4
`define FPM_EV_WARN 5
`define FPM_EVENTS 6

// ----------------------------------------------------------------------
// filter channels
// ----------------------------------------------------------------------
`define FPM_CH_OV 0
`define FPM_CH_UV 1
`define FPM_CH_OT 2
`define FPM_CH_TRK 3
`define FPM_CH_WARN 4
`define FPM_CH_PG 5
`define FPM_CHANNELS 6

// ----------------------------------------------------------------------
// thresholds (percent, mV, degC)
// ----------------------------------------------------------------------
`define FPM_OC_BASE 60
`define FPM_OC_STEP 12
`define FPM_OC_MAXSEL 10
`define FPM_OV_BASE 110
`define FPM_OV_STEP 10
`define FPM_OV_MAXSEL 2
`define FPM_OV_FLOOR_MV 1000
`define FPM_UV_BASE 75
`define FPM_UV_STEP 5
`define FPM_UV_MAXSEL 2
`define FPM_PG_LO_BASE 90
`define FPM_PG_LO_STEP 5
`define FPM_PG_HI 110
`define FPM_TRK_MV 250
`define FPM_OT_TRIP_C 130
`define FPM_OT_RESUME_C 120
`define FPM_WARN_SET_C 120
`define FPM_WARN_HYST_C 3

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FPM_CLK_PS 5000
`define FPM_QUAL_US 6
`define FPM_QUAL_CYCLES ((`FPM_QUAL_US * 1000000 + `FPM_CLK_PS - 1) / `FPM_CLK_PS)
`define FPM_RETRY_MS 130
`define FPM_RETRY_CYCLES ((`FPM_RETRY_MS * 1000) / (`FPM_CLK_PS / 1000) * 1000)

`endif

// ===== src/fpm_pkg.sv
// types of the fault protection monitor
package fpm_pkg;

  typedef enum logic [1:0] {
    FPM_RUN,
    FPM_RETRY,
    FPM_LATCHED
  } fpm_state_t;

  // filter state: one 12-bit stability counter and one output per channel
  typedef struct packed {
    logic [5:0][11:0] cnt;
    logic [5:0] qual;
  } fpm_filt_t;

  // monitor state
  typedef struct packed {
    logic [31:0] cfg;
    logic [5:0] status;
    logic [5:0] mask;
    fpm_state_t st;
    logic [31:0] cnt;
    logic [31:0] rdata;
    logic otHot;
    logic warnRaw;
  } fpm_mon_t;

endpackage

// ===== src/fpm_qual_if.sv
// raw and qualified comparator levels between monitor and filter
`timescale 1ns/1ps
`default_nettype none
interface fpm_qual_if #(parameter int N = 6);
  logic [N-1:0] raw;
  logic [N-1:0] qual;
  modport src (output raw, input qual);
  modport flt (input raw, output qual);
endinterface
`default_nettype wire

// ===== src/fpm_filter.sv
// persistence filter: an output follows its input only after a stable run
`timescale 1ns/1ps
`default_nettype none
`include "fpm_cfg.svh"
module fpm_filter #(
  parameter int QUAL_CYCLES = `FPM_QUAL_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // comparator levels
  fpm_qual_if.flt q
);
  import fpm_pkg::*;

  // ----------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------
  if (QUAL_CYCLES < 1 || QUAL_CYCLES > 4095) begin : g_bad
    $error("QUAL_CYCLES out of range");
  end

  localparam logic [11:0] LAST = 12'(QUAL_CYCLES - 1);

  fpm_filt_t r;
  fpm_filt_t next_r;

  // ----------------------------------------------------------------------
  // per channel stability count
  // ----------------------------------------------------------------------
  always_comb begin
    next_r = r;
    for (int i = 0; i < `FPM_CHANNELS; i++) begin
      if (q.raw[i] == r.qual[i]) begin
        next_r.cnt[i] = 12'h000;
      end else if (r.cnt[i] == LAST) begin
        next_r.cnt[i] = 12'h000;
        next_r.qual[i] = q.raw[i];
      end else begin
        next_r.cnt[i] = r.cnt[i] + 12'h001;
      end
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q.qual = r.qual;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < `FPM_CHANNELS; i++) begin : g_chk
    qual_delay_a: assert property (@(posedge clk) disable iff (rst)
      $changed(r.qual[i]) |-> $past(r.cnt[i]) == LAST && $past(q.raw[i]) == r.qual[i])
      else $error("filtered level changed before its stable run");
  end

endmodule
`default_nettype wire

// ===== verif/fpm_pg_watch.sv
// board-side watcher of the power-good pin
`timescale 1ns/1ps
`default_nettype none
module fpm_pg_watch (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // power-good pin and edge count
  input wire logic pgIn,
  output logic [7:0] riseCnt
);
  logic pgLast;
  // count low-to-high changes of the pin level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pgLast <= 1'b0;
      riseCnt <= 8'h00;
    end else begin
      pgLast <= pgIn;
      if (pgIn && !pgLast) begin
        riseCnt <= riseCnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/fpm_monitor_tb.sv
// self-checking bench of the fault protection monitor
`timescale 1ns/1ps
`default_nettype none
`include "fpm_cfg.svh"
module fpm_monitor_tb;
  localparam int Q = 4;
  localparam int RT = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic rdPend = 1'b0;
  logic [15:0] voutMv = 16'h07D0;
  logic [15:0] vsetMv = 16'h07D0;
  logic [15:0] trackRefMv = 16'h07D0;
  logic [15:0] ioutMa = 16'h01F4;
  logic [15:0] iratedMa = 16'h03E8;
  logic signed [9:0] tempC = 10'h019;
  logic rampActive = 1'b0;
  logic [31:0] regRdata;
  logic turnOff;
  logic power_good_out;
  logic otWarning;
  logic irq;
  logic [7:0] pgRises;
  logic [31:0] expQ[$];
  int error_cnt = 0;
  int n_checks = 0;

  always #2.5 clk = ~clk;

  fpm_monitor #(.RETRY_CYCLES(RT), .QUAL_CYCLES(Q)) DUT (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .voutMv(voutMv), .vsetMv(vsetMv), .trackRefMv(trackRefMv), .ioutMa(ioutMa),
    .iratedMa(iratedMa), .tempC(tempC), .rampActive(rampActive), .turnOff(turnOff),
    .power_good_out(power_good_out), .otWarning(otWarning), .irq(irq)
  );
  fpm_pg_watch board (.clk(clk), .rst(rst), .pgIn(power_good_out), .riseCnt(pgRises));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic after(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    expQ.push_back(exp);
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  function automatic logic [31:0] mkCfg(input int oc, ov, uv, pg, trk, lat);
    return 32'((oc << `FPM_CFG_OC_LSB) | (ov << `FPM_CFG_OV_LSB) | (uv << `FPM_CFG_UV_LSB) |
               (pg << `FPM_CFG_PG_BIT) | (trk << `FPM_CFG_TRK_BIT) | (lat << `FPM_CFG_LATCH_LSB));
  endfunction
  task automatic drive(input int kind, input int v);
    @(posedge clk);
    case (kind)
      0: voutMv <= 16'(v);
      1: ioutMa <= 16'(v);
      2: tempC <= 10'(v);
      default: trackRefMv <= 16'(v);
    endcase
  endtask
  // for a filtered fault, turn-off stays low through the qualify time, then follows the fault
  task automatic expOff(input logic exp, input logic filt);
    if (filt) begin
      after(Q - 2);
      chk("turnOff early", 32'h0000_0000, 32'(turnOff));
    end
    after(filt ? 5 : 2);
    chk("turnOff", 32'(exp), 32'(turnOff));
  endtask
  // back to a healthy operating point, wait out the retry, clear status
  task automatic recover();
    @(posedge clk);
    voutMv <= 16'h07D0;
    vsetMv <= 16'h07D0;
    ioutMa <= 16'h01F4;
    tempC <= 10'h019;
    trackRefMv <= 16'h07D0;
    rampActive <= 1'b0;
    after(RT + 3 * Q + 10);
    chk("turnOff released", 32'h0000_0000, 32'(turnOff));
    regWrite(`FPM_OFS_STATUS, 32'h0000_003F);
  endtask
  // a value at the limit must not trip, one step past it must
  task automatic bound(input int kind, input int bitNo, input int vs, input int a, input int b);
    @(posedge clk);
    vsetMv <= 16'(vs);
    drive(kind, a);
    expOff(1'b0, kind != 1);
    drive(kind, b);
    expOff(1'b1, kind != 1);
    regRead(`FPM_OFS_STATUS, 32'h0000_0001 << bitNo);
    recover();
  endtask

  // read data are compared in the one cycle that they stand
  always @(posedge clk) rdPend <= regRd;
  always @(negedge clk) begin
    if (rdPend) begin
      chk("regRdata", expQ.pop_front(), regRdata);
    end
  end

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    int pgSel[6] = '{0, 0, 1, 1, 0, 0};
    int pgV[6] = '{1800, 1799, 1900, 1899, 2200, 2201};
    int trkRef[4] = '{1750, 1749, 2250, 2251};
    logic [31:0] m;
    void'($urandom(32'h0000_c04c));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    regRead(`FPM_OFS_CFG, mkCfg(10, 2, 0, 0, 0, 0));
    regRead(`FPM_OFS_STATUS, 32'h0000_0000);
    regRead(`FPM_OFS_MASK, 32'h0000_0000);
    regWrite(8'h10, 32'hFFFF_FFFF);
    regRead(8'h10, 32'h0000_0000);
    regRead(`FPM_OFS_CFG, mkCfg(10, 2, 0, 0, 0, 0));
    // power-good window edges, alternating in and out
    for (int i = 0; i < 6; i++) begin
      regWrite(`FPM_OFS_CFG, mkCfg(10, 2, 0, pgSel[i], 0, 0));
      drive(0, pgV[i]);
      after(Q - 2);
      chk("power_good_out early", 32'((i == 0) || (i % 2 == 1)), 32'(power_good_out));
      after(5);
      chk("power_good_out", 32'(i % 2 == 0), 32'(power_good_out));
    end
    chk("pgRises", 32'h0000_0003, 32'(pgRises));
    // overvoltage and undervoltage steps, floor, overcurrent steps
    for (int s = 0; s < 3; s++) begin
      regWrite(`FPM_OFS_CFG, mkCfg(10, s, s, 0, 0, 0));
      bound(0, `FPM_EV_OV, 2000, 20 * (110 + 10 * s), 20 * (110 + 10 * s) + 1);
      bound(0, `FPM_EV_UV, 2000, 20 * (75 + 5 * s), 20 * (75 + 5 * s) - 1);
    end
    regWrite(`FPM_OFS_CFG, mkCfg(10, 0, 0, 0, 0, 0));
    bound(0, `FPM_EV_OV, 800, 1000, 1001);
    for (int s = 0; s <= 10; s += 5) begin
      regWrite(`FPM_OFS_CFG, mkCfg(s, 2, 0, 0, 0, 0));
      bound(1, `FPM_EV_OC, 2000, 10 * (60 + 12 * s), 10 * (60 + 12 * s) + 1);
    end
    // latched overvoltage holds until the configuration is rewritten
    regWrite(`FPM_OFS_CFG, mkCfg(10, 2, 0, 0, 0, 2));
    drive(0, 2700);
    expOff(1'b1, 1'b1);
    drive(0, 2000);
    after(RT + 3 * Q + 10);
    chk("turnOff latched", 32'h0000_0001, 32'(turnOff));
    regWrite(`FPM_OFS_CFG, mkCfg(10, 2, 0, 0, 0, 0));
    after(2);
    chk("turnOff unlatched", 32'h0000_0000, 32'(turnOff));
    recover();
    // overtemperature holds off above the resume level
    drive(2, 131);
    expOff(1'b1, 1'b1);
    drive(2, 121);
    after(RT + 3 * Q + 10);
    chk("turnOff hot", 32'h0000_0001, 32'(turnOff));
    recover();
    // warning with hysteresis, masked and unmasked interrupt
    drive(2, 121);
    after(Q - 2);
    chk("otWarning early", 32'h0000_0000, 32'(otWarning));
    after(5);
    chk("otWarning", 32'h0000_0001, 32'(otWarning));
    chk("irq masked", 32'h0000_0000, 32'(irq));
    regWrite(`FPM_OFS_MASK, 32'h0000_0020);
    after(1);
    chk("irq", 32'h0000_0001, 32'(irq));
    drive(2, 118);
    after(Q + 4);
    chk("otWarning hyst", 32'h0000_0001, 32'(otWarning));
    drive(2, 117);
    after(Q + 4);
    chk("otWarning clear", 32'h0000_0000, 32'(otWarning));
    regRead(`FPM_OFS_STATUS, 32'h0000_0020);
    regWrite(`FPM_OFS_STATUS, 32'h0000_0020);
    after(1);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    recover();
    // tracking: off by default, ramp only, 250 mV either way
    rampActive <= 1'b1;
    drive(3, 1600);
    expOff(1'b0, 1'b1);
    rampActive <= 1'b0;
    regWrite(`FPM_OFS_CFG, mkCfg(10, 2, 0, 0, 1, 0));
    expOff(1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rampActive <= 1'b1;
      drive(3, trkRef[i]);
      expOff(1'(i % 2), 1'b1);
      if (i % 2 == 1) begin
        recover();
      end
    end
    // random masks and in-window voltages
    for (int i = 0; i < 4; i++) begin
      m = $urandom() & 32'h0000_003F;
      regWrite(`FPM_OFS_MASK, m);
      regRead(`FPM_OFS_MASK, m);
      drive(0, 1850 + $urandom() % 300);
      after(Q + 4);
      chk("power_good_out rnd", 32'h0000_0001, 32'(power_good_out));
      chk("turnOff rnd", 32'h0000_0000, 32'(turnOff));
      chk("irq rnd", 32'h0000_0000, 32'(irq));
    end
    after(2);
    wrap_up();
  end

  // hang guard, well past the length of all scenarios
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule
`default_nettype wire
